//--- verilog/clk_div_pkg.sv
package clk_div_pkg;
	// register map: one control register reached through a plain write/read port
	localparam logic [11:0] CTRL_ADDR        = 12'h100;
	localparam logic [7:0]  CTRL_RESET       = 8'h00;
	// field positions inside the control register
	localparam int          SYNC_EN_BIT      = 1;
	localparam int          SYNC_ONCE_BIT    = 2;
	localparam int          RATIO_LO         = 4;
	localparam int          RATIO_HI         = 6;
	// ratio code: value 0..5 selects divide by 1..6
	localparam logic [2:0]  RATIO_MAX_CODE   = 3'h5;
	localparam logic [2:0]  DIV_MAX          = 3'h6;
	// stabilizer limits
	localparam int          CLK_MHZ          = 50;
	localparam int          STABILIZER_MIN_MHZ = 20;
	localparam int          RELOCK_NS        = 5000;
	localparam int          CLK_PERIOD_NS    = 1000 / CLK_MHZ;
	localparam int          RELOCK_CYCLES    = RELOCK_NS / CLK_PERIOD_NS;
	localparam logic [11:0] RELOCK_COUNT     = 12'(RELOCK_CYCLES);

	typedef enum logic [1:0]
	{
		ST_ARMED  = 2'b00,
		ST_DONE   = 2'b01
	} sync_state_t;
endpackage : clk_div_pkg

//--- verilog/div_counter.sv
`timescale 1ns/1ps
// counts input cycles modulo the ratio and marks the phase start
module div_counter
(
	input  wire logic       core_clk,
	input  wire logic       nrst,
	input  wire logic       restart,
	input  wire logic [2:0] ratio,
	output logic      [2:0] count,
	output logic            wrap
);
	logic [2:0] count_reg;
	logic [2:0] count_next;

	always_comb
	begin
		if (restart || count_reg + 3'h1 >= ratio)
			count_next = 3'h0;
		else
			count_next = count_reg + 3'h1;
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
			count_reg <= 3'h0;
		else
			count_reg <= count_next;
	end

	assign count = count_reg;
	assign wrap  = (count_next == 3'h0);
endmodule : div_counter

//--- verilog/sample_clock_divider_sync.sv
`timescale 1ns/1ps
// Function
// RL1: divide incoming sample clock by integer ratio 1 to 6.
// RL2: partner should enable stabilizer for ratios other than 1, 2, 4.
// RL3: external sync input realigns divider phase.
// RL4: control bits 2:1 select resync on every pulse or first after write.
// RL5: accepted sync pulse returns divider counter to its initial state.
// RL6: partner drives one common sync pulse to all devices.
// RL7: stabilizer ineffective below 20 MHz, needs up to 5 us to relock.
// RL8: one output rising edge per N input edges; N=1 passes through.
module sample_clock_divider_sync
(
	input  wire logic       core_clk,
	input  wire logic       nrst,
	input  wire logic       sync_in,
	input  wire logic       reg_wr,
	input  wire logic [11:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	input  wire logic       duty_cycle_stabilizer,
	output logic            conv_tick,
	output logic            sync_applied,
	output logic            stabilizer_advised,
	output logic            stabilizer_locked
);
	////////////////////////////////////////////////////////////////////////////
	// register, phase and handshake state
	logic [7:0]                   ctrl_reg;
	logic [7:0]                   ctrl_next;
	clk_div_pkg::sync_state_t     state_reg;
	clk_div_pkg::sync_state_t     state_next;
	logic                         sync_d_reg;
	logic                         sync_d_next;
	logic                         applied_reg;
	logic                         applied_next;
	logic                         tick_reg;
	logic                         tick_next;
	logic [7:0]                   rdata_reg;
	logic [7:0]                   rdata_next;

	// stabilizer status
	logic [11:0]                  lock_reg;
	logic [11:0]                  lock_next;
	logic                         advised_reg;
	logic                         advised_next;
	logic                         locked_reg;
	logic                         locked_next;

	// decoded control
	logic [2:0]                   ratio_code;
	logic [2:0]                   ratio_code_new;
	logic [2:0]                   ratio;
	logic [2:0]                   count;
	logic                         wrap;
	logic                         sync_rise;
	logic                         sync_enabled;
	logic                         once_mode;
	logic                         accept;
	logic                         ctrl_wr;
	logic                         ratio_wr;
	logic                         relock_done;
	logic                         rate_ok;

	////////////////////////////////////////////////////////////////////////////
	// control decode
	assign ctrl_wr        = reg_wr && (reg_addr == clk_div_pkg::CTRL_ADDR);
	assign ratio_code     = ctrl_reg[clk_div_pkg::RATIO_HI:clk_div_pkg::RATIO_LO];
	assign ratio_code_new = reg_wdata[clk_div_pkg::RATIO_HI:clk_div_pkg::RATIO_LO];
	// any change of the code counts, even between two codes that both mean six
	assign ratio_wr       = ctrl_wr && (ratio_code_new != ratio_code);

	// illegal codes clamp to divide by six rather than stalling the clock
	assign ratio          = (ratio_code > clk_div_pkg::RATIO_MAX_CODE) ? clk_div_pkg::DIV_MAX
	                        : ratio_code + 3'h1; // [RL1]

	// bit1 enables sync; bit2 set means first pulse after a write only
	assign sync_enabled   = ctrl_reg[clk_div_pkg::SYNC_EN_BIT];
	assign once_mode      = ctrl_reg[clk_div_pkg::SYNC_ONCE_BIT];

	// delay flop resets low like the idle pin, so reset makes no false edge
	assign sync_rise      = sync_in && !sync_d_reg; // [RL3]
	assign accept         = sync_rise && sync_enabled
	                        && (!once_mode || state_reg == clk_div_pkg::ST_ARMED); // [RL4]

	// stabilizer is only trusted once the relock wait has run out
	assign relock_done    = (lock_reg == clk_div_pkg::RELOCK_COUNT);
	assign rate_ok        = (clk_div_pkg::CLK_MHZ >= clk_div_pkg::STABILIZER_MIN_MHZ);

	////////////////////////////////////////////////////////////////////////////
	// divider phase counter
	div_counter u_div
	(
		.core_clk (core_clk),
		.nrst     (nrst),
		.restart  (accept), // [RL5]
		.ratio    (ratio),
		.count    (count),
		.wrap     (wrap)
	);

	////////////////////////////////////////////////////////////////////////////
	// register port, sync policy and output pulses
	always_comb
	begin
		ctrl_next    = ctrl_wr ? reg_wdata : ctrl_reg;
		state_next   = state_reg;
		// a write rearms once-mode even if a pulse lands in the same cycle
		if (ctrl_wr)
			state_next = clk_div_pkg::ST_ARMED; // [RL4]
		else if (accept)
			state_next = clk_div_pkg::ST_DONE;
		sync_d_next  = sync_in;
		applied_next = accept; // [RL5]
		tick_next    = wrap; // [RL8]
		rdata_next   = (reg_addr == clk_div_pkg::CTRL_ADDR) ? ctrl_reg : 8'h00;
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			ctrl_reg    <= clk_div_pkg::CTRL_RESET;
			state_reg   <= clk_div_pkg::ST_ARMED;
			sync_d_reg  <= 1'b0;
			applied_reg <= 1'b0;
			tick_reg    <= 1'b0;
			rdata_reg   <= 8'h00;
		end
		else
		begin
			ctrl_reg    <= ctrl_next;
			state_reg   <= state_next;
			sync_d_reg  <= sync_d_next;
			applied_reg <= applied_next;
			tick_reg    <= tick_next;
			rdata_reg   <= rdata_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// stabilizer advice and relock wait
	always_comb
	begin
		// ratio change upsets the stabilizer loop; hold lock low for relock time
		if (ratio_wr)
			lock_next = 12'h000; // [RL7]
		else if (!relock_done)
			lock_next = lock_reg + 12'h001;
		else
			lock_next = lock_reg;
		advised_next = (ratio == 3'h3) || (ratio == 3'h5) || (ratio == 3'h6); // [RL2]
		// judged on the next count so lock drops in the same edge the wait restarts
		locked_next  = duty_cycle_stabilizer && rate_ok
		               && (lock_next == clk_div_pkg::RELOCK_COUNT); // [RL7]
	end

	always_ff @(posedge core_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			lock_reg    <= 12'h000;
			advised_reg <= 1'b0;
			locked_reg  <= 1'b0;
		end
		else
		begin
			lock_reg    <= lock_next;
			advised_reg <= advised_next;
			locked_reg  <= locked_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs, each straight from a flop
	assign conv_tick          = tick_reg;
	assign sync_applied       = applied_reg;
	assign reg_rdata          = rdata_reg;
	assign stabilizer_advised = advised_reg;
	assign stabilizer_locked  = locked_reg;

	////////////////////////////////////////////////////////////////////////////
	// checks on the sync policy and the divider
	a_sync_restart: assert property (@(posedge core_clk) disable iff (!nrst)
		accept |=> count == 3'h0) else $error("sync did not restart divider"); // [RL5]
	a_once_policy: assert property (@(posedge core_clk) disable iff (!nrst)
		once_mode && state_reg == clk_div_pkg::ST_DONE |-> !accept)
		else $error("second sync accepted"); // [RL4]
	a_write_rearm: assert property (@(posedge core_clk) disable iff (!nrst)
		ctrl_wr |=> state_reg == clk_div_pkg::ST_ARMED) else $error("write did not rearm"); // [RL4]
	a_no_sync_off: assert property (@(posedge core_clk) disable iff (!nrst)
		!ctrl_reg[clk_div_pkg::SYNC_EN_BIT] |-> !accept) else $error("sync while disabled"); // [RL3]
	a_tick_period: assert property (@(posedge core_clk) disable iff (!nrst)
		!accept && count == 3'h0 && ratio != 3'h1 |=> count == 3'h1)
		else $error("bad divide step"); // [RL1]
	a_ratio_range: assert property (@(posedge core_clk) disable iff (!nrst)
		ratio >= 3'h1 && ratio <= clk_div_pkg::DIV_MAX) else $error("ratio out of range"); // [RL1]
	a_tick_single: assert property (@(posedge core_clk) disable iff (!nrst)
		wrap && ratio != 3'h1 |=> !wrap || accept || $changed(ratio))
		else $error("two ticks in a row"); // [RL8]
	a_pass_through: assert property (@(posedge core_clk) disable iff (!nrst)
		ratio == 3'h1 && $stable(ratio) |=> conv_tick) else $error("ratio one not passing"); // [RL8]
	a_count_range: assert property (@(posedge core_clk) disable iff (!nrst)
		count < ratio || $changed(ratio)) else $error("count beyond ratio"); // [RL1]
	a_applied_flag: assert property (@(posedge core_clk) disable iff (!nrst)
		accept |=> sync_applied) else $error("sync_applied missing"); // [RL5]
	// checks on the stabilizer status and on unmapped reads
	a_relock_hold: assert property (@(posedge core_clk) disable iff (!nrst)
		lock_next == 12'h000 |=> !stabilizer_locked [*2]) else $error("lock during relock"); // [RL7]
	a_lock_bound: assert property (@(posedge core_clk) disable iff (!nrst)
		lock_reg <= clk_div_pkg::RELOCK_COUNT) else $error("relock count overran"); // [RL7]
	a_rdata_unmapped: assert property (@(posedge core_clk) disable iff (!nrst)
		reg_addr != clk_div_pkg::CTRL_ADDR |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero"); // [RL4]

	// main scenarios
	c_sync_every: cover property (@(posedge core_clk) disable iff (!nrst)
		accept ##[1:20] accept);
	c_ratio_six: cover property (@(posedge core_clk) disable iff (!nrst)
		ratio == 3'h6 && wrap);
	c_once_armed: cover property (@(posedge core_clk) disable iff (!nrst)
		ctrl_wr ##[1:10] accept);
	c_relock_done: cover property (@(posedge core_clk) disable iff (!nrst)
		ratio_wr ##[1:300] stabilizer_locked);
endmodule : sample_clock_divider_sync

//--- verification/sync_source.sv
`timescale 1ns/1ps
// far side: clock-domain owner's sync pulse driver and stabilizer control
module sync_source
(
	input  wire logic core_clk,
	input  wire logic advised,
	output logic      sync_in,
	output logic      stabilizer_en
);
	initial sync_in = 1'b0;
	// stabilizer follows the advice so ratios 3, 5 and 6 stay clean
	assign stabilizer_en = advised;
	// one pulse, meant to fan out to every converter at once
	task pulse;
	begin
		@(posedge core_clk) #1 sync_in = 1'b1;
		@(posedge core_clk) #1 sync_in = 1'b0;
	end
	endtask : pulse
endmodule : sync_source

//--- verification/sample_clock_divider_sync_tb_top.sv
`timescale 1ns/1ps
module sample_clock_divider_sync_tb_top;
	logic        core_clk, nrst, reg_wr, sync_in, stabilizer_en, conv_tick;
	logic        sync_applied, stabilizer_advised, stabilizer_locked;
	logic [11:0] reg_addr;
	logic [7:0]  reg_wdata, reg_rdata;
	int          num_errors, n_compared;
	sample_clock_divider_sync sample_clock_divider_sync_inst (.core_clk(core_clk), .nrst(nrst),
		.sync_in(sync_in), .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .duty_cycle_stabilizer(stabilizer_en), .conv_tick(conv_tick),
		.sync_applied(sync_applied), .stabilizer_advised(stabilizer_advised),
		.stabilizer_locked(stabilizer_locked));
	sync_source sync_source_inst (.core_clk(core_clk), .advised(stabilizer_advised),
		.sync_in(sync_in), .stabilizer_en(stabilizer_en));
	initial
	begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	task cmp(input string nm, input logic [7:0] e, input logic [7:0] v);
		n_compared++;
		if (v !== e)
		begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, v);
		end
	endtask : cmp
	task wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge core_clk) #1 {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
		@(posedge core_clk) #1 reg_wr = 1'b0;
	endtask : wr
	task rd(input logic [11:0] a, input logic [7:0] e);
		reg_addr = a;
		repeat (2) @(posedge core_clk);
		#1 cmp("rdata", e, reg_rdata);
	endtask : rd
	// sync_applied pulses seen across a short window after one pulse
	task sy(input logic [7:0] e);
		logic [7:0] k;
		k = 8'h00;
		// watch while the pulse is driven: the flag stands one cycle only
		fork
			sync_source_inst.pulse();
			for (int i = 0; i < 5; i++)
			begin
				k = k + 8'(sync_applied);
				@(posedge core_clk) #1;
			end
		join
		cmp("sync_applied", e, k);
	endtask : sy
	task t_ratio;
		logic [7:0] k;
		for (int c = 0; c < 8; c++)
		begin
			wr(clk_div_pkg::CTRL_ADDR, 8'(c << 4));
			rd(clk_div_pkg::CTRL_ADDR, 8'(c << 4));
			repeat (8) @(posedge core_clk);
			#1 k = 8'h00;
			// 60 is a multiple of every ratio, so the count is exact
			repeat (60)
			begin
				k = k + 8'(conv_tick);
				@(posedge core_clk) #1;
			end
			cmp("ticks", 8'(60 / ((c > 5) ? 6 : c + 1)), k);
			cmp("advised", 8'(c == 2 || c >= 4), 8'(stabilizer_advised));
		end
		repeat (260) @(posedge core_clk);
		#1 cmp("locked", 8'h01, 8'(stabilizer_locked));
		wr(12'h0FF, 8'h12);
		rd(12'h0FF, 8'h00);
		rd(clk_div_pkg::CTRL_ADDR, 8'h70);
		$display("ratio test done");
	endtask : t_ratio
	task t_sync;
		wr(clk_div_pkg::CTRL_ADDR, 8'h02);
		sy(8'h01);
		sy(8'h01);
		wr(clk_div_pkg::CTRL_ADDR, 8'h06);
		sy(8'h01);
		sy(8'h00);
		wr(clk_div_pkg::CTRL_ADDR, 8'h06);
		sy(8'h01);
		wr(clk_div_pkg::CTRL_ADDR, 8'h00);
		sy(8'h00);
		$display("sync test done");
	endtask : t_sync
	task complete_run;
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : complete_run
	initial
	begin
		{nrst, reg_wr, reg_addr, reg_wdata, num_errors, n_compared} = '0;
		repeat (3) @(posedge core_clk);
		#1 nrst = 1'b1;
		rd(clk_div_pkg::CTRL_ADDR, clk_div_pkg::CTRL_RESET);
		cmp("locked", 8'h00, 8'(stabilizer_locked));
		$display("reset test done");
		t_ratio();
		t_sync();
		complete_run();
	end
endmodule : sample_clock_divider_sync_tb_top
